// File: prt_pkg.sv
// prt_pkg: register map, field positions, reset values and enums of the
// prescaled reload timer; shared by the bus slave, clock selector and core.
package prt_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int CNT_W = 8;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_PINC = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_MODE = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_PRE = 5'h0C;
	localparam logic [ADDR_W-1:0] OFF_CNT = 5'h10;
	// control register fields
	localparam int CTRL_START = 0;
	localparam int CTRL_STATUS = 1;
	localparam int CTRL_STOP = 2;
	localparam int CTRL_EDGE = 4;
	localparam int CTRL_UNDF = 5;
	// pin control fields
	localparam int PINC_POL = 0;
	localparam int PINC_OSTOP = 2;
	localparam int PINC_SEL = 3;
	// mode select fields
	localparam int MODE_LSB = 0;
	localparam int CKS_LSB = 4;
	localparam logic [CNT_W-1:0] CNT_RST = 8'hFF;
	localparam logic [CNT_W-1:0] REG_RST = 8'h00;
	localparam int DIV_F2 = 2;
	localparam int DIV_F8 = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		PRT_MODE_TIMER = 3'h0,
		PRT_MODE_PULSE = 3'h1,
		PRT_MODE_EVENT = 3'h2,
		PRT_MODE_WIDTH = 3'h3,
		PRT_MODE_PERIOD = 3'h4
	} prt_mode_type;
	typedef enum logic [1:0] {
		PRT_CKS_F1 = 2'h0,
		PRT_CKS_F2 = 2'h1,
		PRT_CKS_F8 = 2'h2,
		PRT_CKS_OSC = 2'h3
	} prt_cks_type;
	typedef enum logic [2:0] {
		PRT_ST_STOPPED = 3'b001,
		PRT_ST_ARMED = 3'b010,
		PRT_ST_COUNTING = 3'b100
	} prt_state_type;
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		return (a == OFF_CTRL) || (a == OFF_PINC) || (a == OFF_MODE) ||
			(a == OFF_PRE) || (a == OFF_CNT);
	endfunction
endpackage

// File: prt_count_source.sv
// prt_count_source: one-cycle count source ticks from aclk or the oscillator.
// assumes onchip_osc_clock is already synchronous to aclk and slower than it.
`timescale 1ns/10ps
module prt_count_source #(
	parameter int DIV_W = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [1:0] sel,
	input wire logic onchip_osc_clock,
	output logic tick
);
	logic [DIV_W-1:0] div_q;
	logic osc_q;
	wire osc_rise = onchip_osc_clock & ~osc_q;
	wire f2_tick = (div_q[0] == 1'b1);
	wire f8_tick = (div_q == DIV_W'(prt_pkg::DIV_F8 - 1));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_q <= '0;
			osc_q <= 1'b0;
		end else begin
			div_q <= div_q + 1'b1;
			osc_q <= onchip_osc_clock;
		end
	end

	// four selectable sources
	always_comb begin
		case (prt_pkg::prt_cks_type'(sel))
			prt_pkg::PRT_CKS_F1: tick = 1'b1;
			prt_pkg::PRT_CKS_F2: tick = f2_tick;
			prt_pkg::PRT_CKS_F8: tick = f8_tick;
			prt_pkg::PRT_CKS_OSC: tick = osc_rise;
			default: tick = 1'b0;
		endcase
	end
endmodule // prt_count_source

// File: prt_axil_slave.sv
// prt_axil_slave: AXI4-Lite slave front end, one write and one read at a time.
// assumes the core answers rd_data combinationally from s_axi_araddr.
`timescale 1ns/10ps
module prt_axil_slave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [prt_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [prt_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [prt_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [prt_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_en,
	output logic [prt_pkg::ADDR_W-1:0] wr_addr,
	output logic [prt_pkg::CNT_W-1:0] wr_data,
	input wire logic [prt_pkg::CNT_W-1:0] rd_data
);
	logic aw_full_q, w_full_q, strb_q;
	logic [prt_pkg::CNT_W-1:0] wdata_q;
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire do_wr = aw_full_q & w_full_q & ~s_axi_bvalid;
	wire wr_hit = prt_pkg::addr_hit(wr_addr);
	wire ar_take = s_axi_arvalid & s_axi_arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			strb_q <= 1'b0;
			wdata_q <= '0;
			wr_addr <= '0;
			wr_en <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= prt_pkg::RESP_OKAY;
		end else begin
			wr_en <= do_wr & wr_hit & strb_q;
			if (aw_take) begin
				wr_addr <= s_axi_awaddr;
				aw_full_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (w_take) begin
				wdata_q <= s_axi_wdata[prt_pkg::CNT_W-1:0];
				strb_q <= s_axi_wstrb[0];
				w_full_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_wr) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? prt_pkg::RESP_OKAY : prt_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end
	assign wr_data = wdata_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= prt_pkg::RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_data};
			s_axi_rresp <= prt_pkg::addr_hit(s_axi_araddr) ?
				prt_pkg::RESP_OKAY : prt_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule // prt_axil_slave

// File: prt_timer.sv
// prt_timer: 8-bit reload timer behind an 8-bit reload prescaler, AXI4-Lite.
// assumes synchronous inputs; the pin pads resolve level from the enables.
`timescale 1ns/10ps
// How it works
// - 8-bit prescaler feeds 8-bit timer, shared addresses
// - five modes selectable; four behave as timer
// - prescaler source f1, f2, f8 or oscillator
// - timer steps per prescaler underflow
// - underflowing counter reloads, keeps counting
// - period is (n+1)(m+1) source cycles
// - writing start bit one begins counting
// - writing start bit zero halts counting
// - forced stop resets start, status, counters
// - interrupt request at each timer underflow
// - stage read returns live counter value
// - write loads reload; stopped loads counter too
// - running prescaler write lands at next tick
// - running timer write lands at next prescaler underflow
// - flags clear on zero write, one ignored
// - timer mode leaves pin to other users
// - pulse mode toggles pin at each underflow
// - polarity bit picks starting output level
// - output stop hides pulse, counting continues
// - pin select routes output to one pin
// - mode write drives starting output level
module prt_timer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [prt_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [prt_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [prt_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [prt_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic onchip_osc_clock,
	output logic timer_irq,
	output logic timer_io_pin_a_o,
	output logic timer_io_pin_a_oe,
	output logic timer_io_pin_b_o,
	output logic timer_io_pin_b_oe
);
	localparam int W = prt_pkg::CNT_W;

	logic wr_en;
	logic [prt_pkg::ADDR_W-1:0] wr_addr;
	logic [W-1:0] wr_data;
	logic [W-1:0] rd_data;
	logic tick;

	prt_pkg::prt_state_type state_q, state_d;
	logic [W-1:0] pre_rel_q, pre_cnt_q, tim_rel_q, tim_cnt_q;
	logic pre_pend_q, tim_pend_q;
	logic edge_flag_q, undf_flag_q;
	logic [W-1:0] pinc_q, mode_q;
	logic level_q;

	prt_axil_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_data(rd_data)
	);

	prt_count_source #(
		.DIV_W(3)
	) u_src (
		.aclk(aclk),
		.aresetn(aresetn),
		.sel(mode_q[prt_pkg::CKS_LSB +: 2]),
		.onchip_osc_clock(onchip_osc_clock),
		.tick(tick)
	);

	// write decode
	wire wr_ctrl = wr_en && (wr_addr == prt_pkg::OFF_CTRL);
	wire wr_pinc = wr_en && (wr_addr == prt_pkg::OFF_PINC);
	wire wr_mode = wr_en && (wr_addr == prt_pkg::OFF_MODE);
	wire wr_pre = wr_en && (wr_addr == prt_pkg::OFF_PRE);
	wire wr_tim = wr_en && (wr_addr == prt_pkg::OFF_CNT);
	wire fstop = wr_ctrl && wr_data[prt_pkg::CTRL_STOP];
	wire start_bit = (state_q != prt_pkg::PRT_ST_STOPPED);
	wire counting = (state_q == prt_pkg::PRT_ST_COUNTING);

	// measurement modes are not built; they count as in timer mode
	wire [2:0] mode_f = mode_q[prt_pkg::MODE_LSB +: 3];
	wire pulse_mode = (mode_f == prt_pkg::PRT_MODE_PULSE);

	// one prescaler step per source tick while counting
	wire pre_step = counting && tick;
	wire pre_uf = pre_step && (pre_cnt_q == '0) && !pre_pend_q;
	wire tim_step = pre_uf;
	wire tim_uf = tim_step && (tim_cnt_q == '0) && !tim_pend_q;

	// start/halt handshake with the count source
	always_comb begin
		case (state_q)
			prt_pkg::PRT_ST_STOPPED:
				state_d = (wr_ctrl && wr_data[prt_pkg::CTRL_START]) ?
					prt_pkg::PRT_ST_ARMED : prt_pkg::PRT_ST_STOPPED;
			prt_pkg::PRT_ST_ARMED:
				state_d = tick ? prt_pkg::PRT_ST_COUNTING : prt_pkg::PRT_ST_ARMED;
			prt_pkg::PRT_ST_COUNTING:
				state_d = prt_pkg::PRT_ST_COUNTING;
			default:
				state_d = prt_pkg::PRT_ST_STOPPED;
		endcase
		if (wr_ctrl && !wr_data[prt_pkg::CTRL_START]) begin
			state_d = prt_pkg::PRT_ST_STOPPED;
		end
		if (fstop) begin
			state_d = prt_pkg::PRT_ST_STOPPED;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= prt_pkg::PRT_ST_STOPPED;
		end else begin
			state_q <= state_d;
		end
	end

	// prescaler stage; a running write must not swallow this tick's step
	always_ff @(posedge aclk) begin
		if (!aresetn || fstop) begin
			pre_rel_q <= prt_pkg::CNT_RST;
			pre_cnt_q <= prt_pkg::CNT_RST;
			pre_pend_q <= 1'b0;
		end else begin
			if (wr_pre) begin
				pre_rel_q <= wr_data;
			end
			if (wr_pre && !counting) begin
				pre_cnt_q <= wr_data;
				pre_pend_q <= 1'b0;
			end else if (pre_step) begin
				if (pre_pend_q || pre_cnt_q == '0) begin
					pre_cnt_q <= pre_rel_q;
				end else begin
					pre_cnt_q <= pre_cnt_q - 1'b1;
				end
				pre_pend_q <= wr_pre;
			end else if (wr_pre) begin
				pre_pend_q <= 1'b1;
			end
		end
	end

	// timer stage; same shape, so a write never costs an underflow step
	always_ff @(posedge aclk) begin
		if (!aresetn || fstop) begin
			tim_rel_q <= prt_pkg::CNT_RST;
			tim_cnt_q <= prt_pkg::CNT_RST;
			tim_pend_q <= 1'b0;
		end else begin
			if (wr_tim) begin
				tim_rel_q <= wr_data;
			end
			if (wr_tim && !counting) begin
				tim_cnt_q <= wr_data;
				tim_pend_q <= 1'b0;
			end else if (tim_step) begin
				if (tim_pend_q || tim_cnt_q == '0) begin
					tim_cnt_q <= tim_rel_q;
				end else begin
					tim_cnt_q <= tim_cnt_q - 1'b1;
				end
				tim_pend_q <= wr_tim;
			end else if (wr_tim) begin
				tim_pend_q <= 1'b1;
			end
		end
	end

	// flags: a same-cycle underflow beats the software clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			edge_flag_q <= 1'b0;
			undf_flag_q <= 1'b0;
			timer_irq <= 1'b0;
		end else begin
			timer_irq <= tim_uf;
			if (wr_ctrl && !wr_data[prt_pkg::CTRL_EDGE]) begin
				edge_flag_q <= 1'b0;
			end
			if (tim_uf) begin
				undf_flag_q <= 1'b1;
			end else if (wr_ctrl && !wr_data[prt_pkg::CTRL_UNDF]) begin
				undf_flag_q <= 1'b0;
			end
		end
	end

	// configuration; mode changes while running are the caller's hazard
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pinc_q <= prt_pkg::REG_RST;
			mode_q <= prt_pkg::REG_RST;
		end else begin
			if (wr_pinc) begin
				pinc_q <= wr_data;
			end
			if (wr_mode) begin
				mode_q <= wr_data;
			end
		end
	end

	// pulse level: preset on mode write, toggled on timer underflow
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_q <= 1'b0;
		end else if (wr_mode) begin
			level_q <= pinc_q[prt_pkg::PINC_POL];
		end else if (pulse_mode && tim_uf) begin
			level_q <= ~level_q;
		end
	end

	// pin drive; output stop only drops the enable, counting goes on
	wire drive = pulse_mode && !pinc_q[prt_pkg::PINC_OSTOP];
	wire pin_b = pinc_q[prt_pkg::PINC_SEL];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_io_pin_a_o <= 1'b0;
			timer_io_pin_a_oe <= 1'b0;
			timer_io_pin_b_o <= 1'b0;
			timer_io_pin_b_oe <= 1'b0;
		end else begin
			timer_io_pin_a_o <= level_q;
			timer_io_pin_b_o <= level_q;
			timer_io_pin_a_oe <= drive && !pin_b;
			timer_io_pin_b_oe <= drive && pin_b;
		end
	end

	// read mux; stage addresses show the live counters, not reloads
	wire [W-1:0] ctrl_rd = {2'b00, undf_flag_q, edge_flag_q, 1'b0, 1'b0,
		counting, start_bit};
	always_comb begin
		case (s_axi_araddr)
			prt_pkg::OFF_CTRL: rd_data = ctrl_rd;
			prt_pkg::OFF_PINC: rd_data = pinc_q;
			prt_pkg::OFF_MODE: rd_data = mode_q;
			prt_pkg::OFF_PRE: rd_data = pre_cnt_q;
			prt_pkg::OFF_CNT: rd_data = tim_cnt_q;
			default: rd_data = '0;
		endcase
	end

	// checks
	force_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		fstop |=> (pre_cnt_q == 8'hFF) && (tim_cnt_q == 8'hFF) && !start_bit && !counting)
		else $error("forced stop did not reset the stages");

	start_arm_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_ctrl && wr_data[prt_pkg::CTRL_START] && !fstop) |=> start_bit)
		else $error("start write did not arm the counter");

	halt_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_ctrl && !wr_data[prt_pkg::CTRL_START]) |=> !start_bit && !counting)
		else $error("halt write did not stop counting");

	pre_dec_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(pre_step && !fstop && !wr_pre && !pre_pend_q && pre_cnt_q != 8'h00)
		|=> pre_cnt_q == $past(pre_cnt_q) - 8'h01)
		else $error("prescaler did not step down by one");

	pre_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(pre_uf && !fstop && !wr_pre) |=> pre_cnt_q == $past(pre_rel_q))
		else $error("prescaler did not reload on underflow");

	irq_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
		tim_uf |=> timer_irq ##1 (timer_irq == $past(tim_uf)))
		else $error("underflow did not raise the interrupt");

	pulse_toggle_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(pulse_mode && tim_uf && !wr_mode) |=> ##1 timer_io_pin_a_o != $past(timer_io_pin_a_o))
		else $error("pulse output did not toggle");

	stopped_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_tim && !counting && !fstop) |=> tim_cnt_q == $past(wr_data) && tim_rel_q == tim_cnt_q)
		else $error("stopped write did not load the timer");

	run_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_tim && counting && !fstop && !tim_step) |=> tim_cnt_q == $past(tim_cnt_q))
		else $error("running timer write landed early");

	pre_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_pre && counting && !fstop && !pre_pend_q && pre_cnt_q != 8'h00)
		|=> pre_cnt_q == $past(pre_cnt_q) - {7'h00, $past(pre_step)})
		else $error("running prescaler write landed early");

	flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_ctrl && !wr_data[prt_pkg::CTRL_UNDF] && !tim_uf) |=> !undf_flag_q)
		else $error("underflow flag did not clear");

	status_sync_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_q == prt_pkg::PRT_ST_ARMED && !tick) |=> !counting)
		else $error("status set before a source tick");

	out_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(pinc_q[prt_pkg::PINC_OSTOP] && !wr_pinc) |=> !timer_io_pin_a_oe && !timer_io_pin_b_oe)
		else $error("stopped output still driven");
endmodule // prt_timer

// File: prt_timer_bench.sv
// prt_timer_bench: self-checking bench for the prescaled reload timer.
// assumes the design answers on AXI4-Lite and pulses timer_irq once per underflow.
`timescale 1ns/10ps
module prt_timer_bench;
	typedef struct packed {
		logic [4:0] a;
		logic w;
		logic [7:0] d;
		logic [31:0] q;
		logic [1:0] r;
	} prt_row_type;
	localparam int OSC_DIV = 5;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [4:0] awaddr = 5'h00, araddr = 5'h00;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq, ao, aoe, bo, boe;
	logic [1:0] bresp, rresp, r;
	logic osc = 1'b0;
	logic [2:0] oc_q = 3'h0;
	int failures = 0, checked = 0, p, c;
	int dv [4] = '{1, prt_pkg::DIV_F2, prt_pkg::DIV_F8, OSC_DIV};
	prt_row_type rows [9] = '{
		'{prt_pkg::OFF_CTRL, 1'b0, 8'h00, 32'h0, prt_pkg::RESP_OKAY},
		'{prt_pkg::OFF_PINC, 1'b0, 8'h00, 32'h0, prt_pkg::RESP_OKAY},
		'{prt_pkg::OFF_MODE, 1'b0, 8'h00, 32'h0, prt_pkg::RESP_OKAY},
		'{prt_pkg::OFF_PRE, 1'b0, 8'h00, 32'hFF, prt_pkg::RESP_OKAY},
		'{prt_pkg::OFF_CNT, 1'b0, 8'h00, 32'hFF, prt_pkg::RESP_OKAY},
		'{prt_pkg::OFF_PRE, 1'b1, 8'h5A, 32'h5A, prt_pkg::RESP_OKAY},
		'{prt_pkg::OFF_CNT, 1'b1, 8'h03, 32'h03, prt_pkg::RESP_OKAY},
		'{5'h14, 1'b1, 8'h77, 32'h0, prt_pkg::RESP_SLVERR},
		'{prt_pkg::OFF_PRE, 1'b0, 8'h00, 32'h5A, prt_pkg::RESP_OKAY}
	};

	always #20 aclk = ~aclk;

	// oscillator stand-in: one-cycle high every OSC_DIV cycles, kept slower than aclk
	always @(posedge aclk) begin
		oc_q <= (oc_q == 3'(OSC_DIV - 1)) ? 3'h0 : oc_q + 3'h1;
		osc <= (oc_q == 3'h0);
	end

	prt_timer u_prt_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid),
		.s_axi_awready(awready),
		.s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid),
		.s_axi_wready(wready),
		.s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid),
		.s_axi_bready(bready),
		.s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid),
		.s_axi_arready(arready),
		.s_axi_rdata(rdata),
		.s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid),
		.s_axi_rready(rready),
		.onchip_osc_clock(osc),
		.timer_irq(irq),
		.timer_io_pin_a_o(ao),
		.timer_io_pin_a_oe(aoe),
		.timer_io_pin_b_o(bo),
		.timer_io_pin_b_oe(boe)
	);

	task automatic wrap_up;
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic tmo;
		failures++;
		$display("wait limit reached at %0t", $time);
		wrap_up();
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
		end
	endtask

	// readies are sampled at the falling edge: they cannot change before the next rising edge
	task automatic wr(input logic [4:0] a, input logic [7:0] d, output logic [1:0] rs);
		logic ta, tw, tb;
		int n;
		tb = 1'b0;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!tb) begin
			@(negedge aclk);
			ta = awready;
			tw = wready;
			tb = bvalid;
			rs = bresp;
			n++;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
			if (n > 100) tmo();
		end
	endtask

	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] rs);
		logic ta, tv;
		int n;
		tv = 1'b0;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!tv) begin
			@(negedge aclk);
			ta = arready;
			tv = rvalid;
			d = rdata;
			rs = rresp;
			n++;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tv) rready <= 1'b0;
			if (n > 100) tmo();
		end
	endtask

	task automatic rc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] rs;
		rd(a, d, rs);
		chk(d & m, e);
	endtask

	// cycles between two consecutive interrupt pulses
	task automatic per(output int pp);
		int n;
		n = 0;
		pp = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (irq !== 1'b1 && n < 500);
		do begin
			@(negedge aclk);
			pp++;
		end while (irq !== 1'b1 && pp < 500);
		if (n >= 500 || pp >= 500) tmo();
	endtask

	task automatic tog(input logic pb, output int cc);
		logic l, v;
		cc = 0;
		@(negedge aclk);
		l = pb ? bo : ao;
		repeat (40) begin
			@(negedge aclk);
			v = pb ? bo : ao;
			if (v !== l) cc++;
			l = v;
		end
	endtask

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w) begin
				wr(rows[i].a, rows[i].d, r);
				chk({30'h0, r}, {30'h0, rows[i].r});
			end
			rd(rows[i].a, q, r);
			chk(q, rows[i].q);
			chk({30'h0, r}, {30'h0, rows[i].r});
		end
		$display("register rows done");
		wr(prt_pkg::OFF_PRE, 8'h02, r);
		for (int i = 0; i < 4; i++) begin
			wr(prt_pkg::OFF_CTRL, 8'h00, r);
			wr(prt_pkg::OFF_MODE, {2'h0, 2'(i), 4'h0}, r);
			wr(prt_pkg::OFF_CTRL, 8'h01, r);
			per(p);
			chk(32'(p), 32'(12 * dv[i]));
		end
		rc(prt_pkg::OFF_CTRL, 32'h3, 32'h3);
		wr(prt_pkg::OFF_CTRL, 8'h00, r);
		wr(prt_pkg::OFF_CNT, 8'h44, r);
		repeat (30) @(posedge aclk);
		rc(prt_pkg::OFF_CNT, 32'hFF, 32'h44);
		rc(prt_pkg::OFF_CTRL, 32'h3, 32'h0);
		$display("source and stop tests done");
		wr(prt_pkg::OFF_MODE, 8'h02, r);
		wr(prt_pkg::OFF_PRE, 8'h02, r);
		wr(prt_pkg::OFF_CNT, 8'h03, r);
		wr(prt_pkg::OFF_CTRL, 8'h01, r);
		per(p);
		chk(32'(p), 32'd12);
		wr(prt_pkg::OFF_CNT, 8'h07, r);
		// first interval may straddle the landing of the new reload
		per(p);
		per(p);
		chk(32'(p), 32'd24);
		wr(prt_pkg::OFF_PRE, 8'h00, r);
		per(p);
		per(p);
		chk(32'(p), 32'd8);
		$display("running write tests done");
		wr(prt_pkg::OFF_CTRL, 8'h20, r);
		rc(prt_pkg::OFF_CTRL, 32'h21, 32'h20);
		wr(prt_pkg::OFF_CTRL, 8'h00, r);
		rc(prt_pkg::OFF_CTRL, 32'h21, 32'h0);
		wr(prt_pkg::OFF_CTRL, 8'h20, r);
		rc(prt_pkg::OFF_CTRL, 32'h21, 32'h0);
		wr(prt_pkg::OFF_CTRL, 8'h01, r);
		per(p);
		wr(prt_pkg::OFF_CTRL, 8'h04, r);
		rc(prt_pkg::OFF_CTRL, 32'h7, 32'h0);
		rc(prt_pkg::OFF_PRE, 32'hFF, 32'hFF);
		rc(prt_pkg::OFF_CNT, 32'hFF, 32'hFF);
		$display("flag and forced stop tests done");
		wr(prt_pkg::OFF_PINC, 8'h01, r);
		wr(prt_pkg::OFF_MODE, 8'h01, r);
		repeat (3) @(negedge aclk);
		chk(32'({ao, aoe, boe}), 32'h6);
		wr(prt_pkg::OFF_PRE, 8'h00, r);
		wr(prt_pkg::OFF_CNT, 8'h03, r);
		wr(prt_pkg::OFF_CTRL, 8'h01, r);
		per(p);
		chk(32'(p), 32'd4);
		tog(1'b0, c);
		chk(32'(c), 32'd10);
		wr(prt_pkg::OFF_PINC, 8'h05, r);
		repeat (3) @(negedge aclk);
		chk(32'(aoe), 32'h0);
		per(p);
		chk(32'(p), 32'd4);
		wr(prt_pkg::OFF_PINC, 8'h09, r);
		per(p);
		tog(1'b1, c);
		chk(32'(c), 32'd10);
		chk(32'({aoe, boe}), 32'h1);
		wr(prt_pkg::OFF_CTRL, 8'h00, r);
		wr(prt_pkg::OFF_PINC, 8'h08, r);
		wr(prt_pkg::OFF_MODE, 8'h01, r);
		repeat (3) @(negedge aclk);
		chk(32'(bo), 32'h0);
		wr(prt_pkg::OFF_MODE, 8'h00, r);
		wstrb <= 4'hE;
		repeat (3) @(negedge aclk);
		chk(32'({aoe, boe}), 32'h0);
		wr(prt_pkg::OFF_PINC, 8'h07, r);
		chk({30'h0, r}, {30'h0, prt_pkg::RESP_OKAY});
		wstrb <= 4'hF;
		rc(prt_pkg::OFF_PINC, 32'hFF, 32'h08);
		$display("pulse output tests done");
		wrap_up();
	end
endmodule // prt_timer_bench
